// [rtl/cfd_dispatch_top.sv]
// Purpose: Range dispatch, estimator packing and beam assembly
// Assumes: Inputs synchronous to clk_i; estimator FIFOs pop on ready
// Notes: Host control bus carries control words only
// Summary of operation
// [R1] Route each range to its engine FIFO
// [R2] Write strobes only when board addressed
// [R3] Ranges per beam from 64 to 512
// [R4] Advanced mode overlaps two ranges with neighbours
// [R5] Control words set algorithm and range count
// [R6] Four engines feed each of four estimators
// [R7] Pack 4, 8, 4 bit fields into 16
// [R8] Intensity top, velocity middle, bandwidth low
// [R9] Loads target one, all or groups
// [R10] Assemble beam with head and tail words
// [R11] Check expected result word count per beam
// [R12] Push assembled beam into output FIFO
// [R13] On error keep writing framed dummy data
// [R14] Interrupt on each new host control word
// [R15] Serial ports use three lines each way
// [R16] Host bus carries control only
// [R17] Forward lookup tables over serial links
// [R18] Upstream sends data range by range
`timescale 1ns/100ps
`include "cfd_params.svh"
module cfd_dispatch_top #(
  parameter int unsigned N_ENG = `CFD_ENGINES,
  parameter int unsigned N_EST = `CFD_EST,
  parameter logic [3:0] BOARD_ID = 4'h1,
  parameter int unsigned TIMEOUT_CYC = `CFD_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Stream bus input, one range per strobe
  input wire logic in_valid_i,
  input wire logic [3:0] in_board_i,
  input wire logic [15:0] in_data_i,
  output logic [N_ENG-1:0] eng_wr_o,
  output logic [15:0] eng_data_o,
  // Control word write from the master
  input wire logic cw_wr_i,
  input wire logic [15:0] cw_data_i,
  output logic [1:0] alg_o,
  output logic [9:0] range_cnt_o,
  // Estimator parameter strobes
  input wire logic [N_EST-1:0] est_valid_i,
  input wire logic [N_EST-1:0][3:0] est_int_i,
  input wire logic [N_EST-1:0][7:0] est_vel_i,
  input wire logic [N_EST-1:0][3:0] est_bw_i,
  // Beam start and error
  input wire logic beam_start_i,
  input wire logic error_i,
  output logic beam_err_o,
  // Output stream FIFO write
  input wire logic out_ready_i,
  output logic out_wr_o,
  output logic [15:0] out_data_o,
  // Host control FIFO
  input wire logic host_cw_push_i,
  output logic host_irq_o,
  // Serial load and table forward
  input wire logic [4:0] load_sel_i,
  input wire logic [2:0] load_ser_i,
  output logic [N_ENG+N_EST-1:0][2:0] eng_ser_o
);
  initial begin
    if (N_ENG != `CFD_ENGINES || N_EST * `CFD_ENG_PER_EST != N_ENG) begin
      $error("Engine and estimator counts must be 16 and 4");
    end
    if (TIMEOUT_CYC < 2) begin
      $error("Timeout too short");
    end
  end

  typedef struct packed {
    cfd_pkg::cfd_alg_t alg;
    logic [9:0] range_cnt;
    logic [9:0] rng_idx;
    logic [N_ENG-1:0] wr;
    logic [15:0] wdata;
    cfd_pkg::cfd_asm_state_t st;
    logic [9:0] words;
    logic [31:0] tmo;
    logic err;
    logic irq;
  } cfd_top_st_t;
  cfd_top_st_t s_q, s_d;

  logic [N_EST-1:0] pk_valid;
  logic [N_EST-1:0][15:0] pk_word;
  logic [N_EST-1:0] pop;

  for (genvar g = 0; g < N_EST; g++) begin : g_est
    // Each estimator serves four engines
    cfd_vel_pack u_pack ( // [R6]
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .valid_i(est_valid_i[g]),
      .intensity_i(est_int_i[g]),
      .velocity_i(est_vel_i[g]),
      .bandwidth_i(est_bw_i[g]),
      .valid_o(pk_valid[g]),
      .word_o(pk_word[g])
    );
  end

  cfd_load_demux #(.N_ENG(N_ENG), .N_EST(N_EST)) u_demux (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sel_i(load_sel_i),
    .ser_i(load_ser_i), // [R17]
    .ser_o(eng_ser_o)
  );

  function automatic logic [9:0] clamp_range(input logic [9:0] r);
    logic [9:0] v;
    v = r;
    if (r < `CFD_RANGE_MIN) v = `CFD_RANGE_MIN;
    if (r > `CFD_RANGE_MAX) v = `CFD_RANGE_MAX;
    return v;
  endfunction

  logic [9:0] rpe;
  logic [4:0] own;
  logic [9:0] pos;
  logic [9:0] beam_words;
  assign rpe = s_q.range_cnt >> 4;
  assign beam_words = s_q.range_cnt;

  always_comb begin
    s_d = s_q;
    s_d.wr = '0;
    // Host side carries only the push event, no sample data
    s_d.irq = host_cw_push_i; // [R14] [R16]
    // Clear first so that any error set below in this cycle wins
    if (cw_wr_i && !error_i) s_d.err = 1'b0;
    own = 5'h00;
    pos = 10'h000;
    if (cw_wr_i) begin
      s_d.alg = cw_data_i[`CFD_CW_MODE_BIT] ? cfd_pkg::CFD_ALG_ADV : cfd_pkg::CFD_ALG_CONV; // [R5]
      s_d.range_cnt = clamp_range(cw_data_i[`CFD_CW_RANGE_MSB:`CFD_CW_RANGE_LSB]); // [R3] [R5]
    end
    if (beam_start_i) begin
      s_d.rng_idx = '0;
    end else if (in_valid_i && in_board_i == BOARD_ID) begin // [R2] [R18]
      own = 5'((s_q.rng_idx / rpe) & 10'h00f);
      pos = s_q.rng_idx % rpe;
      s_d.wdata = in_data_i;
      s_d.wr[own[3:0]] = 1'b1; // [R1]
      if (s_q.alg == cfd_pkg::CFD_ALG_ADV) begin
        // Boundary ranges shared with neighbours
        if (pos < `CFD_OVERLAP && own != 5'h00) begin
          s_d.wr[own[3:0] - 4'h1] = 1'b1; // [R4]
        end
        if (pos >= rpe - `CFD_OVERLAP && own != 5'h0f) begin
          s_d.wr[own[3:0] + 4'h1] = 1'b1; // [R4]
        end
      end
      if (s_q.rng_idx != s_q.range_cnt - 10'h001) begin
        s_d.rng_idx = s_q.rng_idx + 10'h001;
      end
    end
    pop = '0;
    unique case (s_q.st)
      cfd_pkg::CFD_ASM_IDLE: begin
        if (beam_start_i) begin
          s_d.words = '0;
          s_d.tmo = '0;
          s_d.st = cfd_pkg::CFD_ASM_HEAD;
        end
      end
      cfd_pkg::CFD_ASM_HEAD: begin
        if (out_ready_i) begin
          s_d.st = s_q.err ? cfd_pkg::CFD_ASM_FILL : cfd_pkg::CFD_ASM_BODY; // [R10] [R13]
        end
      end
      cfd_pkg::CFD_ASM_BODY: begin
        s_d.tmo = s_q.tmo + 32'h1;
        // No pop once the beam is complete, so no extra word slips out
        if (out_ready_i && s_q.words < beam_words) begin
          for (int unsigned e = 0; e < N_EST; e++) begin
            if (pk_valid[e] && pop == '0) pop[e] = 1'b1;
          end
        end
        if (pop != '0) begin
          s_d.words = s_q.words + 10'h001;
          s_d.tmo = '0;
        end
        if (s_q.words >= beam_words) begin
          s_d.st = cfd_pkg::CFD_ASM_TAIL;
        end else if (error_i || s_q.tmo >= TIMEOUT_CYC) begin
          s_d.err = 1'b1; // [R11]
          s_d.st = cfd_pkg::CFD_ASM_FILL;
        end
      end
      cfd_pkg::CFD_ASM_FILL: begin
        if (out_ready_i) begin
          s_d.words = s_q.words + 10'h001; // [R13]
          if (s_q.words >= beam_words - 10'h001) s_d.st = cfd_pkg::CFD_ASM_TAIL;
        end
      end
      cfd_pkg::CFD_ASM_TAIL: begin
        if (out_ready_i) begin
          s_d.st = cfd_pkg::CFD_ASM_IDLE;
        end
      end
      default: s_d.st = cfd_pkg::CFD_ASM_IDLE;
    endcase
    if (error_i) s_d.err = 1'b1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{alg: cfd_pkg::CFD_ALG_CONV, range_cnt: `CFD_RANGE_RST,
               st: cfd_pkg::CFD_ASM_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  logic [15:0] pop_word;
  always_comb begin
    pop_word = `CFD_DUMMY_WORD;
    for (int unsigned e = 0; e < N_EST; e++) begin
      if (pop[e]) pop_word = pk_word[e];
    end
  end

  // Output FIFO write, handshake combinational
  always_comb begin
    out_wr_o = 1'b0;
    out_data_o = `CFD_DUMMY_WORD;
    unique case (s_q.st)
      cfd_pkg::CFD_ASM_HEAD: begin
        out_wr_o = out_ready_i; // [R12]
        out_data_o = `CFD_HEAD_WORD;
      end
      cfd_pkg::CFD_ASM_BODY: begin
        out_wr_o = (pop != '0); // [R12]
        out_data_o = pop_word;
      end
      cfd_pkg::CFD_ASM_FILL: begin
        out_wr_o = out_ready_i; // [R13]
        out_data_o = `CFD_DUMMY_WORD;
      end
      cfd_pkg::CFD_ASM_TAIL: begin
        out_wr_o = out_ready_i;
        out_data_o = `CFD_TAIL_WORD;
      end
      default: begin
        out_wr_o = 1'b0;
      end
    endcase
  end

  assign eng_wr_o = s_q.wr;
  assign eng_data_o = s_q.wdata;
  assign alg_o = s_q.alg;
  assign range_cnt_o = s_q.range_cnt;
  assign beam_err_o = s_q.err;
  assign host_irq_o = s_q.irq;

  property p_no_foreign;
    @(posedge clk_i) disable iff (!reset_n_i)
      (in_valid_i && in_board_i != BOARD_ID && !beam_start_i) |=> (eng_wr_o == '0);
  endproperty
  a_no_foreign: assert property (p_no_foreign) else $error("Write for other board"); // [R2]
  property p_range_legal;
    @(posedge clk_i) disable iff (!reset_n_i)
      (range_cnt_o >= `CFD_RANGE_MIN) && (range_cnt_o <= `CFD_RANGE_MAX);
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("Range count out of bounds"); // [R3]
  property p_cw_adopt;
    @(posedge clk_i) disable iff (!reset_n_i)
      cw_wr_i |=> (alg_o[0] == $past(cw_data_i[15]));
  endproperty
  a_cw_adopt: assert property (p_cw_adopt) else $error("Mode not adopted"); // [R5]
  property p_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
      host_cw_push_i |=> host_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Missing host interrupt"); // [R14]
  property p_head_first;
    @(posedge clk_i) disable iff (!reset_n_i)
      (s_q.st == cfd_pkg::CFD_ASM_IDLE && beam_start_i) ##1 out_ready_i
        |-> out_wr_o && out_data_o == `CFD_HEAD_WORD;
  endproperty
  a_head_first: assert property (p_head_first) else $error("Head word missing"); // [R10]
  property p_one_wr;
    @(posedge clk_i) disable iff (!reset_n_i)
      (s_q.alg == cfd_pkg::CFD_ALG_CONV) |-> $onehot0(eng_wr_o);
  endproperty
  a_one_wr: assert property (p_one_wr) else $error("Conventional mode multi write"); // [R1]
  property p_fill_on_err;
    @(posedge clk_i) disable iff (!reset_n_i)
      (s_q.st == cfd_pkg::CFD_ASM_FILL && out_ready_i)
        |-> out_wr_o && out_data_o == `CFD_DUMMY_WORD;
  endproperty
  a_fill_on_err: assert property (p_fill_on_err) else $error("Dummy data not written"); // [R13]
  property p_tail;
    @(posedge clk_i) disable iff (!reset_n_i)
      (s_q.st == cfd_pkg::CFD_ASM_BODY && s_q.words == beam_words)
        |=> (s_q.st == cfd_pkg::CFD_ASM_TAIL);
  endproperty
  a_tail: assert property (p_tail) else $error("Beam count not checked"); // [R11]
endmodule

// [common/cfd_params.svh]
// Purpose: Constants for the colour flow range dispatch and packing block
// Assumes: 40 MHz clock
// Notes: Offsets, fields and counts as macros
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH
`define CFD_ENGINES 16
`define CFD_EST 4
`define CFD_ENG_PER_EST 4
`define CFD_RANGE_MIN 10'h040
`define CFD_RANGE_MAX 10'h200
`define CFD_RANGE_RST 10'h040
`define CFD_OVERLAP 2
`define CFD_INT_MSB 15
`define CFD_INT_LSB 12
`define CFD_VEL_MSB 11
`define CFD_VEL_LSB 4
`define CFD_BW_MSB 3
`define CFD_BW_LSB 0
`define CFD_CW_MODE_BIT 15
`define CFD_CW_BOARD_MSB 14
`define CFD_CW_BOARD_LSB 11
`define CFD_CW_RANGE_MSB 9
`define CFD_CW_RANGE_LSB 0
`define CFD_HEAD_WORD 16'hf00d
`define CFD_TAIL_WORD 16'he0de
`define CFD_DUMMY_WORD 16'h0000
`define CFD_SEL_ALL 5'h10
`define CFD_SEL_EVEN 5'h11
`define CFD_SEL_ODD 5'h12
`define CFD_SEL_EST 5'h13
`define CFD_TIMEOUT_NS 100000
`define CFD_CLK_MHZ 40
`define CFD_TIMEOUT_CYC ((`CFD_TIMEOUT_NS * `CFD_CLK_MHZ) / 1000)
`endif

// [common/cfd_pkg.sv]
// Purpose: Types for the colour flow range dispatch and packing block
// Assumes: Used with cfd_params.svh
// Notes: Nothing imported by users
package cfd_pkg;
  typedef enum logic [1:0] {
    CFD_ALG_CONV = 2'b00,
    CFD_ALG_ADV = 2'b01
  } cfd_alg_t;
  typedef enum logic [2:0] {
    CFD_ASM_IDLE = 3'b000,
    CFD_ASM_HEAD = 3'b001,
    CFD_ASM_BODY = 3'b011,
    CFD_ASM_TAIL = 3'b010,
    CFD_ASM_FILL = 3'b110
  } cfd_asm_state_t;
endpackage

// [rtl/cfd_vel_pack.sv]
// Purpose: Packs three estimator parameters into one word
// Assumes: Fields arrive together with a strobe
// Notes: One per group of four engines
`timescale 1ns/100ps
`include "cfd_params.svh"
module cfd_vel_pack (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic valid_i,
  input wire logic [3:0] intensity_i,
  input wire logic [7:0] velocity_i,
  input wire logic [3:0] bandwidth_i,
  output logic valid_o,
  output logic [15:0] word_o
);
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } cfd_pack_st_t;
  cfd_pack_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.valid = valid_i;
    if (valid_i) begin
      s_d.word[`CFD_INT_MSB:`CFD_INT_LSB] = intensity_i; // [R7] [R8]
      s_d.word[`CFD_VEL_MSB:`CFD_VEL_LSB] = velocity_i; // [R7] [R8]
      s_d.word[`CFD_BW_MSB:`CFD_BW_LSB] = bandwidth_i; // [R7] [R8]
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign valid_o = s_q.valid;
  assign word_o = s_q.word;
  property p_pack_fields;
    @(posedge clk_i) disable iff (!reset_n_i)
      valid_i |=> (word_o == {$past(intensity_i), $past(velocity_i), $past(bandwidth_i)});
  endproperty
  a_pack_fields: assert property (p_pack_fields) else $error("Packed word wrong"); // [R8]
endmodule

// [rtl/cfd_load_demux.sv]
// Purpose: Routes a serial load to one, all or a group of modules
// Assumes: Selector stable during a load
// Notes: Three lines each way per engine port
`timescale 1ns/100ps
`include "cfd_params.svh"
module cfd_load_demux #(
  parameter int unsigned N_ENG = 16,
  parameter int unsigned N_EST = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] sel_i,
  input wire logic [2:0] ser_i,
  output logic [N_ENG+N_EST-1:0][2:0] ser_o
);
  initial begin
    if (N_ENG != `CFD_ENGINES || N_EST > `CFD_EST) begin
      $error("Select codes assume 16 engines and at most 4 estimators");
    end
  end
  typedef struct packed {
    logic [N_ENG+N_EST-1:0][2:0] ser;
  } cfd_dmx_st_t;
  cfd_dmx_st_t s_q, s_d;
  function automatic logic hit(input logic [4:0] sel, input int unsigned idx);
    logic r;
    r = 1'b0;
    if (sel == `CFD_SEL_ALL) r = 1'b1;
    else if (sel == `CFD_SEL_EVEN) r = (idx < N_ENG) && (idx % 2 == 0);
    else if (sel == `CFD_SEL_ODD) r = (idx < N_ENG) && (idx % 2 == 1);
    else if (sel == `CFD_SEL_EST) r = (idx >= N_ENG);
    else r = (32'(sel) == idx);
    return r;
  endfunction
  always_comb begin
    s_d = s_q;
    for (int unsigned i = 0; i < N_ENG + N_EST; i++) begin
      s_d.ser[i] = hit(sel_i, i) ? ser_i : 3'h0; // [R9] [R15]
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ser_o = s_q.ser;
  property p_all_hit;
    @(posedge clk_i) disable iff (!reset_n_i)
      (sel_i == `CFD_SEL_ALL) |=> (ser_o[0] == $past(ser_i)) && (ser_o[N_ENG] == $past(ser_i));
  endproperty
  a_all_hit: assert property (p_all_hit) else $error("Broadcast load missed"); // [R9]
  property p_single;
    @(posedge clk_i) disable iff (!reset_n_i)
      (sel_i == 5'h03) |=> (ser_o[2] == 3'h0) && (ser_o[3] == $past(ser_i));
  endproperty
  a_single: assert property (p_single) else $error("Single load misrouted"); // [R9]
endmodule

// [verification/cfd_upstream_model.sv]
// Purpose: Upstream board model that drives the stream bus
// Assumes: The bench calls it at the falling edge
// Notes: An idle bus shows the inverse of the last word
`timescale 1ns/100ps
module cfd_upstream_model (
  output logic valid_o,
  output logic [3:0] board_o,
  output logic [15:0] data_o
);
  initial begin
    valid_o = 1'b0;
    board_o = 4'h0;
    data_o = 16'h0000;
  end

  // One range word per cycle, range by range
  task automatic put(input logic [3:0] board, input logic [15:0] data);
    valid_o = 1'b1;
    board_o = board;
    data_o = data;
  endtask

  // Released bus no longer holds the last word
  task automatic idle();
    valid_o = 1'b0;
    board_o = ~board_o;
    data_o = ~data_o;
  endtask
endmodule

// [verification/test_flow_range_dispatch_packing.sv]
// Purpose: Self-checking bench for range dispatch and beam packing
// Assumes: Inputs driven at the falling edge; idle limit shortened to 20
// Notes: Output words are sampled mid-cycle into a queue
`timescale 1ns/100ps
`include "cfd_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_flow_range_dispatch_packing;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic in_valid_i;
  logic [3:0] in_board_i;
  logic [15:0] in_data_i;
  logic [15:0] eng_wr_o;
  logic [15:0] eng_data_o;
  logic cw_wr_i = 1'b0;
  logic [15:0] cw_data_i = 16'h0000;
  logic [1:0] alg_o;
  logic [9:0] range_cnt_o;
  logic [3:0] est_valid_i = 4'h0;
  logic [3:0][3:0] est_int_i = '0;
  logic [3:0][7:0] est_vel_i = '0;
  logic [3:0][3:0] est_bw_i = '0;
  logic beam_start_i = 1'b0;
  logic error_i = 1'b0;
  logic beam_err_o;
  logic out_ready_i = 1'b1;
  logic out_wr_o;
  logic [15:0] out_data_o;
  logic host_cw_push_i = 1'b0;
  logic host_irq_o;
  logic [4:0] load_sel_i = 5'h00;
  logic [2:0] load_ser_i = 3'h0;
  logic [19:0][2:0] eng_ser_o;
  logic [15:0] outq[$];
  int err_count = 0;
  int compares = 0;
  // Control word, expected mode, expected range count
  logic [27:0] rows [6] = '{{16'h0040, 2'h0, 10'h040}, {16'h8200, 2'h1, 10'h200},
    {16'h0010, 2'h0, 10'h040}, {16'h03ff, 2'h0, 10'h200}, {16'h8100, 2'h1, 10'h100},
    {16'h7880, 2'h0, 10'h080}};
  logic [4:0] codes [6] = '{5'h03, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13};

  always #12.5 clk_i = ~clk_i;

  cfd_upstream_model u_up (.valid_o(in_valid_i), .board_o(in_board_i), .data_o(in_data_i));

  cfd_dispatch_top #(.TIMEOUT_CYC(20)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .in_valid_i(in_valid_i), .in_board_i(in_board_i), .in_data_i(in_data_i),
    .eng_wr_o(eng_wr_o), .eng_data_o(eng_data_o), .cw_wr_i(cw_wr_i),
    .cw_data_i(cw_data_i), .alg_o(alg_o), .range_cnt_o(range_cnt_o),
    .est_valid_i(est_valid_i), .est_int_i(est_int_i), .est_vel_i(est_vel_i),
    .est_bw_i(est_bw_i), .beam_start_i(beam_start_i), .error_i(error_i),
    .beam_err_o(beam_err_o), .out_ready_i(out_ready_i), .out_wr_o(out_wr_o),
    .out_data_o(out_data_o), .host_cw_push_i(host_cw_push_i), .host_irq_o(host_irq_o),
    .load_sel_i(load_sel_i), .load_ser_i(load_ser_i), .eng_ser_o(eng_ser_o));

  // Mid-cycle capture of output FIFO writes
  always @(negedge clk_i) begin
    #5;
    if (out_wr_o === 1'b1) outq.push_back(out_data_o);
  end

  task automatic stop_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  task automatic setcw(input logic [15:0] d);
    cyc(1);
    cw_wr_i = 1'b1;
    cw_data_i = d;
    cyc(1);
    cw_wr_i = 1'b0;
    cw_data_i = ~d;
  endtask

  task automatic start();
    beam_start_i = 1'b1;
    cyc(1);
    beam_start_i = 1'b0;
  endtask

  function automatic bit hit(input logic [4:0] s, input int j);
    if (s < 5'h10) return j == s;
    if (s == 5'h10) return 1'b1;
    if (s == 5'h13) return j >= 16;
    return j < 16 && j % 2 == (s == 5'h11 ? 0 : 1);
  endfunction

  task automatic stream(input logic [3:0] brd, input int n, input int per, input bit adv);
    logic [15:0] m;
    int k;
    int e;
    start();
    for (int i = 0; i <= n; i++) begin
      if (i > 0) begin
        k = i - 1;
        e = k / per;
        m = 16'h0001 << e;
        if (adv && k % per < 2 && e > 0) m = m | (16'h0001 << (e - 1));
        if (adv && k % per >= per - 2 && e < 15) m = m | (16'h0001 << (e + 1));
        if (brd != 4'h1) m = 16'h0000;
        `CHK(eng_wr_o, m)
        if (m != 16'h0000) `CHK(eng_data_o, 16'h1000 + k[15:0])
      end
      if (i < n) u_up.put(brd, 16'h1000 + i[15:0]);
      else u_up.idle();
      cyc(1);
    end
  endtask

  task automatic beam(input int feed, input int keep, input bit err, input bit stall);
    logic [15:0] exp[$];
    int w;
    outq = {};
    exp.push_back(`CFD_HEAD_WORD);
    start();
    cyc(1);
    for (int i = 0; i < feed; i++) begin
      est_valid_i = 4'h1 << (i % 4);
      est_int_i[i % 4] = i[3:0];
      est_vel_i[i % 4] = 8'h80 ^ i[7:0];
      est_bw_i[i % 4] = ~i[3:0];
      if (i < keep) exp.push_back({i[3:0], 8'h80 ^ i[7:0], ~i[3:0]});
      cyc(1);
    end
    est_valid_i = 4'h0;
    cyc(2);
    error_i = err;
    for (w = 0; w < 400 && !(outq.size() > 0 && outq[$] === `CFD_TAIL_WORD); w++) begin
      out_ready_i = !(stall && w % 3 == 1);
      cyc(1);
    end
    out_ready_i = 1'b1;
    error_i = 1'b0;
    if (w == 400) begin
      err_count++;
      stop_test();
    end
    while (exp.size() < 65) exp.push_back(`CFD_DUMMY_WORD);
    exp.push_back(`CFD_TAIL_WORD);
    `CHK(outq.size(), exp.size())
    foreach (exp[j]) if (j < outq.size()) `CHK(outq[j], exp[j])
  endtask

  initial begin
    cyc(8);
    reset_n_i = 1'b1;
    cyc(1);
    `CHK(range_cnt_o, `CFD_RANGE_RST)
    `CHK(alg_o, 2'h0)
    `CHK(eng_wr_o, 16'h0000)
    `CHK(out_wr_o, 1'b0)
    `CHK(host_irq_o, 1'b0)
    endt("reset");
    foreach (rows[r]) begin
      setcw(rows[r][27:12]);
      `CHK(alg_o, rows[r][11:10])
      `CHK(range_cnt_o, rows[r][9:0])
    end
    endt("control");
    setcw(16'h0040);
    stream(4'h1, 64, 4, 1'b0);
    stream(4'h2, 8, 4, 1'b0);
    setcw(16'h8200);
    stream(4'h1, 512, 32, 1'b1);
    cyc(700);
    endt("dispatch");
    setcw(16'h0040);
    beam(64, 64, 1'b0, 1'b0);
    beam(0, 0, 1'b0, 1'b0);
    setcw(16'h0040);
    beam(10, 10, 1'b1, 1'b0);
    `CHK(beam_err_o, 1'b1)
    beam(4, 0, 1'b0, 1'b1);
    setcw(16'h0040);
    `CHK(beam_err_o, 1'b0)
    endt("beam");
    host_cw_push_i = 1'b1;
    cyc(1);
    host_cw_push_i = 1'b0;
    `CHK(host_irq_o, 1'b1)
    cyc(1);
    `CHK(host_irq_o, 1'b0)
    endt("irq");
    foreach (codes[c]) begin
      load_sel_i = codes[c];
      load_ser_i = codes[c][2:0] ^ 3'h6;
      cyc(1);
      for (int j = 0; j < 20; j++) begin
        `CHK(eng_ser_o[j], hit(codes[c], j) ? load_ser_i : 3'h0)
      end
    end
    endt("serial");
    setcw(16'h8200);
    reset_n_i = 1'b0;
    cyc(1);
    reset_n_i = 1'b1;
    cyc(1);
    `CHK(range_cnt_o, `CFD_RANGE_RST)
    `CHK(alg_o, 2'h0)
    endt("reset again");
    stop_test();
  end
endmodule
